/* File: design/ddr_read_dev.sv */
// ddr device read path, mode programming and power-up tracking
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ddr_map.svh"
// Behaviour
// R1 - controller holds no-ops, clock enable low
// R2 - controller runs clock 200 us first
// R3 - controller issues no-op, raises clock enable
// R4 - controller precharges all, then enables loop
// R5 - loop reset restarts loop, 200 cycles lock
// R6 - controller precharges all again before refresh
// R7 - controller issues at least two refreshes
// R8 - final mode set with loop reset low
// R9 - read latency two, two-half or three
// R10 - remaining elements follow programmed burst order
// R11 - bursts of four concatenate, eight interrupted
// R12 - gapless back-to-back reads same device only
// R13 - every new read interrupts previous burst
// R14 - burst stop truncates output after latency
// R15 - controller stops read before following write
// R16 - precharge no earlier than half burst
// R17 - precharge cuts burst of eight, four completes
// R18 - controller waits row-active time before precharge
// R19 - controller waits row cycle between opens
// R20 - controller waits after mode sets, loop lock; model sends the mode set on the cycle after the extended mode set
// R21 - strobe toggles per element, released after
module ddr_read_dev
  import ddr_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int ROW_W = 13
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic link_ck,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe
);
  // ==========================================================
  // helpers
  function automatic logic [3:0] burst_col(input logic [3:0] col,
    input logic [3:0] idx, input logic [2:0] blc, input logic bt);
    logic [3:0] mask;
    logic [3:0] sum;
    mask = (blc == `BL_2) ? `MASK_2 : (blc == `BL_4) ? `MASK_4 : `MASK_8;
    sum = col + idx;
    return (col & ~mask) | ((bt ? (col ^ idx) : sum) & mask);
  endfunction
  function automatic logic [3:0] blen(input logic [2:0] blc);
    return (blc == `BL_2) ? `BLEN_2 : (blc == `BL_4) ? `BLEN_4 : `BLEN_8;
  endfunction
  function automatic logic [2:0] lat_edges(input logic [2:0] clc);
    return (clc == `CL_2) ? `LAT_E2 : (clc == `CL_25) ? `LAT_E25 : `LAT_E3;
  endfunction

  // ==========================================================
  // link pin capture and clock edge finding
  localparam int SW = ROW_W + 8;
  logic [SW-1:0] pins_s;
  logic ck_s, ck_d_q, cke_s, cs_b_s;
  logic [2:0] cmd_s;
  logic [1:0] ba_s;
  logic [ROW_W-1:0] addr_s;
  link_sync #(.W(SW)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d({link_ck, cke, cs_b, ras_b, cas_b, we_b, ba, addr}),
    .q(pins_s)
  );
  assign {ck_s, cke_s, cs_b_s, cmd_s, ba_s, addr_s} = pins_s;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ck_d_q <= 1'b0;
    else
      ck_d_q <= ck_s;
  end
  wire rise = ck_s & ~ck_d_q;
  wire edge_s = ck_s ^ ck_d_q; // both link edges carry data
  wire cmd_ok = rise & cke_s & ~cs_b_s;
  wire is_read = cmd_ok & (cmd_s == `CMD_READ);
  wire is_bst = cmd_ok & (cmd_s == `CMD_BST);
  wire is_pre = cmd_ok & (cmd_s == `CMD_PRE);
  wire is_ref = cmd_ok & (cmd_s == `CMD_REF);
  wire is_mset = cmd_ok & (cmd_s == `CMD_MSET);
  wire mode_wr = is_mset & (ba_s == `BA_MODE);
  wire ext_wr = is_mset & (ba_s == `BA_EXT);
  wire lrst = mode_wr & addr_s[`MF_LRST];
  wire pre_all = is_pre & addr_s[`MF_ALL];

  // ==========================================================
  // mode and extended mode registers, loop lock counter
  logic [2:0] bl_q, cl_q;
  logic bt_q, dll_en_q;
  logic [7:0] dll_cnt_q;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bl_q <= `RST_BL;
      cl_q <= `RST_CL;
      bt_q <= 1'b0;
      dll_en_q <= 1'b0;
      dll_cnt_q <= 8'h00;
    end
    else
    begin
      if (mode_wr)
      begin
        bl_q <= addr_s[`MF_BL];
        cl_q <= addr_s[`MF_CL];
        bt_q <= addr_s[`MF_BT];
      end
      if (ext_wr)
        dll_en_q <= ~addr_s[`EF_DLL_OFF];
      if (lrst)
        dll_cnt_q <= 8'h00; // R5
      else if (rise && dll_cnt_q != `DLL_LOCK_CYC)
        dll_cnt_q <= dll_cnt_q + 8'h01;
    end
  end
  wire dll_locked = dll_en_q & (dll_cnt_q == `DLL_LOCK_CYC);

  // ==========================================================
  // power-up progress as seen from the command pins
  init_state_e st_q, st_d;
  logic [3:0] ref_cnt_q;
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      S_POWER: if (cke_s) st_d = S_CLK_ON;
      S_CLK_ON: if (pre_all) st_d = S_PRE1;
      S_PRE1: if (ext_wr) st_d = S_EXT;
      S_EXT: if (lrst) st_d = S_LRST;
      S_LRST: if (pre_all) st_d = S_PRE2;
      S_PRE2: if (is_ref && ref_cnt_q + 4'h1 >= `MIN_REFRESH) st_d = S_REF;
      S_REF: if (mode_wr && !addr_s[`MF_LRST]) st_d = S_READY;
      S_READY: st_d = S_READY;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= S_POWER;
      ref_cnt_q <= 4'h0;
    end
    else
    begin
      st_q <= st_d;
      if (is_ref && ref_cnt_q != 4'hf)
        ref_cnt_q <= ref_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // latency pipeline, one slot per link edge
  logic [`PIPE_DEPTH-1:0] rd_pipe_q, stop_pipe_q, all_pipe_q;
  logic [1:0] bank_pipe_q [0:`PIPE_DEPTH-1];
  logic [3:0] col_pipe_q [0:`PIPE_DEPTH-1];
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pipe_q <= '0;
      stop_pipe_q <= '0;
      all_pipe_q <= '0;
      for (int i = 0; i < `PIPE_DEPTH; i++)
      begin
        bank_pipe_q[i] <= 2'h0;
        col_pipe_q[i] <= 4'h0;
      end
    end
    else if (edge_s)
    begin
      rd_pipe_q <= {rd_pipe_q[`PIPE_DEPTH-2:0], is_read};
      stop_pipe_q <= {stop_pipe_q[`PIPE_DEPTH-2:0], is_bst | is_pre};
      all_pipe_q <= {all_pipe_q[`PIPE_DEPTH-2:0], is_bst | pre_all};
      bank_pipe_q[0] <= ba_s;
      col_pipe_q[0] <= addr_s[3:0];
      for (int i = 1; i < `PIPE_DEPTH; i++)
      begin
        bank_pipe_q[i] <= bank_pipe_q[i-1];
        col_pipe_q[i] <= col_pipe_q[i-1];
      end
    end
  end

  // ==========================================================
  // burst sequencing taps
  logic burst_act_q, drive_en_q;
  logic [3:0] bidx_q, bcol_q;
  logic [1:0] bbank_q;
  word_t mem_q [0:15];
  wire [2:0] tap_i = lat_edges(cl_q) - 3'h1; // R9
  wire rd_tap = rd_pipe_q[tap_i];
  wire [3:0] col_tap = col_pipe_q[tap_i];
  wire start = rd_tap & drive_en_q; // R13
  wire stop_hit = stop_pipe_q[tap_i] &
    (all_pipe_q[tap_i] | (bank_pipe_q[tap_i] == bbank_q)); // R14 R17
  wire last = (bidx_q == blen(bl_q)); // R11
  wire [3:0] first_ix = burst_col(col_tap, `IDX_ZERO, bl_q, bt_q);
  wire [3:0] next_ix = burst_col(bcol_q, bidx_q, bl_q, bt_q); // R10

  // data and strobe, changing on every link edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      burst_act_q <= 1'b0;
      bidx_q <= `IDX_ZERO;
      bcol_q <= 4'h0;
      bbank_q <= 2'h0;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe <= 1'b0;
    end
    else if (edge_s)
    begin
      if (start)
      begin
        burst_act_q <= 1'b1; // R11
        bidx_q <= `IDX_ONE;
        bcol_q <= col_tap;
        bbank_q <= bank_pipe_q[tap_i];
        dq_o <= mem_q[first_ix];
        dqs_o <= 1'b1;
        dq_oe <= 1'b1;
        dqs_oe <= 1'b1;
      end
      else if (burst_act_q && (stop_hit || last))
      begin
        burst_act_q <= 1'b0; // R14
        dq_oe <= 1'b0;
        dqs_oe <= 1'b0; // R21
        dqs_o <= 1'b0;
      end
      else if (burst_act_q)
      begin
        dq_o <= mem_q[next_ix]; // R10
        dqs_o <= ~dqs_o; // R21
        bidx_q <= bidx_q + `IDX_ONE;
      end
    end
  end

  // ==========================================================
  // wishbone slave: status, mode, control and read data memory
  logic ack_q;
  wire req = wb_cyc & wb_stb;
  wire commit = req & ack_q & wb_we;
  wire sel_mem = (wb_adr[`ADR_PAGE] == `PAGE_MEM);
  wire [3:0] mem_ix = wb_adr[`ADR_WORD];
  wire [31:0] st_word = {23'h00_0000, burst_act_q, ref_cnt_q, dll_locked,
    st_q};
  wire [31:0] mode_word = {24'h00_0000, dll_en_q, cl_q, bt_q, bl_q};
  wire [31:0] rdat_d = sel_mem ? {16'h0000, mem_q[mem_ix]} :
    (wb_adr == `ADR_STATUS) ? st_word :
    (wb_adr == `ADR_MODE) ? mode_word :
    (wb_adr == `ADR_CTRL) ? {31'h0000_0000, drive_en_q} : 32'h0000_0000;
  assign wb_ack = ack_q;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      drive_en_q <= `RST_DRIVE;
      for (int i = 0; i < 16; i++)
        mem_q[i] <= 16'h0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q)
        wb_dat_r <= rdat_d;
      if (commit && wb_adr == `ADR_CTRL && wb_sel[0])
        drive_en_q <= wb_dat_w[0];
      if (commit && sel_mem && wb_sel[0])
        mem_q[mem_ix][7:0] <= wb_dat_w[7:0];
      if (commit && sel_mem && wb_sel[1])
        mem_q[mem_ix][15:8] <= wb_dat_w[15:8];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ack_once_a:
    assert property (ack_q |=> !ack_q) else $error("ack longer than one");
  loop_restart_a: // R5
    assert property (lrst |=> (dll_cnt_q == 8'h00) && !dll_locked)
    else $error("loop reset did not restart lock count");
  latency_tap_a: // R9
    assert property (edge_s && rd_pipe_q[lat_edges(cl_q) - 3'h1] &&
      drive_en_q |=> burst_act_q && dq_oe)
    else $error("read data not started at latency");
  burst_order_a: // R10
    assert property (edge_s && burst_act_q && !last && !stop_hit && !start
      |=> bidx_q == $past(bidx_q) + `IDX_ONE && dq_oe)
    else $error("burst element skipped");
  burst_end_a: // R11
    assert property (edge_s && burst_act_q && last && !start
      |=> !burst_act_q && !dq_oe)
    else $error("burst ran past its length");
  read_interrupt_a: // R13
    assert property (edge_s && start |=> bidx_q == `IDX_ONE &&
      bcol_q == $past(col_tap) && dqs_o)
    else $error("new read did not restart burst");
  stop_trunc_a: // R14
    assert property (edge_s && burst_act_q && stop_hit && !start
      |=> !dq_oe && !dqs_oe)
    else $error("burst stop did not truncate");
  pre_marks_a: // R17
    assert property (edge_s && is_pre |=> stop_pipe_q[0] &&
      (all_pipe_q[0] == $past(addr_s[`MF_ALL])))
    else $error("precharge not queued as stop");
  strobe_toggle_a: // R21
    assert property (edge_s && burst_act_q && !last && !stop_hit && !start
      |=> dqs_o != $past(dqs_o))
    else $error("strobe did not toggle");
  strobe_pair_a: // R21
    assert property (dq_oe == dqs_oe) else $error("strobe and data apart");
endmodule

/* File: design/ddr_map.svh */
// address map, field positions, encodings and counts of the ddr read block
`ifndef DDR_MAP_SVH
`define DDR_MAP_SVH
// ==========================================================
// register bus map (byte addresses)
`define ADR_STATUS 8'h00
`define ADR_MODE 8'h04
`define ADR_CTRL 8'h08
`define PAGE_MEM 2'h1
`define ADR_PAGE 7:6
`define ADR_WORD 5:2
// ==========================================================
// mode and extended mode fields on the address pins
`define MF_BL 2:0
`define MF_BT 3
`define MF_CL 6:4
`define MF_LRST 8
`define MF_ALL 10
`define EF_DLL_OFF 0
`define BA_MODE 2'h0
`define BA_EXT 2'h1
// ==========================================================
// burst length and read latency codes
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BLEN_2 4'h2
`define BLEN_4 4'h4
`define BLEN_8 4'h8
`define MASK_2 4'h1
`define MASK_4 4'h3
`define MASK_8 4'h7
`define CL_2 3'h2
`define CL_25 3'h6
`define CL_3 3'h3
`define LAT_E2 3'h4
`define LAT_E25 3'h5
`define LAT_E3 3'h6
`define PIPE_DEPTH 6
// ==========================================================
// command codes as {ras, cas, we}
`define CMD_MSET 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ROWOPEN 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_BST 3'h6
`define CMD_NOP 3'h7
// ==========================================================
// counts and reset values
`define DLL_LOCK_CYC 8'hc8
`define MIN_REFRESH 4'h2
`define IDX_ZERO 4'h0
`define IDX_ONE 4'h1
`define RST_BL `BL_4
`define RST_CL `CL_3
`define RST_DRIVE 1'b1
`endif

/* File: design/ddr_pkg.sv */
// types shared by the ddr read block
package ddr_pkg;
  // ==========================================================
  // initialisation progress, gray coded along the power-up path
  typedef enum logic [2:0] {
    S_POWER = 3'h0,
    S_CLK_ON = 3'h1,
    S_PRE1 = 3'h3,
    S_EXT = 3'h2,
    S_LRST = 3'h6,
    S_PRE2 = 3'h7,
    S_REF = 3'h5,
    S_READY = 3'h4
  } init_state_e;
  typedef logic [15:0] word_t;
endpackage

/* File: design/link_sync.sv */
// two flip-flop synchroniser for link pins
`timescale 1ns/1ps
module link_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: testbench/ddr_ctrl_model.sv */
// memory controller model: link clock, power-up and command issue
`timescale 1ns/1ps
`include "ddr_map.svh"
module ddr_ctrl_model (
  output logic link_ck,
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] ba,
  output logic [12:0] addr
);
  realtime t_cmd;
  // ==========
  // free running link clock, phase unrelated to clk_sys
  initial
  begin
    cke = 1'b0;
    cs_b = 1'b0;
    {ras_b, cas_b, we_b} = `CMD_NOP;
    ba = 2'h0;
    addr = 13'h0000;
    link_ck = 1'b0;
    #37;
    forever #200 link_ck = ~link_ck;
  end
  // pins move on ck fall so they are stable around the taking rise
  task cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge link_ck);
    {ras_b, cas_b, we_b} <= c;
    ba <= b;
    addr <= a;
    @(posedge link_ck);
    t_cmd = $realtime;
  endtask
  // idle cycles; address lines flip since nobody cares about them
  task no_operation_cmd(input int n);
    repeat (n) cmd(`CMD_NOP, ~ba, ~addr);
  endtask
  // ==========
  // power-up sequence
  task power_up;
    repeat (500) @(posedge link_ck);
    @(negedge link_ck);
    cke <= 1'b1;
    no_operation_cmd(1);
    cmd(`CMD_PRE, 2'h0, 13'h0400);
    cmd(`CMD_MSET, `BA_EXT, 13'h0000);
    cmd(`CMD_MSET, `BA_MODE, 13'h0132);
    no_operation_cmd(200);
    cmd(`CMD_PRE, 2'h0, 13'h0400);
    repeat (2) cmd(`CMD_REF, 2'h0, 13'h0000);
    cmd(`CMD_MSET, `BA_MODE, 13'h0032);
    no_operation_cmd(2);
  endtask
endmodule

/* File: testbench/ddr_read_dev_tb.sv */
// self-checking bench of the ddr read block
`timescale 1ns/1ps
`include "ddr_map.svh"
module ddr_read_dev_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h3;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r, rd;
  logic wb_ack, link_ck, cke, cs_b, ras_b, cas_b, we_b;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [15:0] dq_o, dq_i;
  logic dq_oe, dqs_o, dqs_oe, dqs_i, oe_d, dqs_d;
  logic [15:0] mem[16];
  logic [15:0] got[$];
  logic [2:0] cur_bl, cls[3];
  logic cur_il, drv;
  realtime t0, t_first;
  int n_mismatch, check_count, seed, hp, i;
  // released pins show a moving pattern, not the last value
  assign dq_i = dq_oe ? dq_o : {16{clk_sys}};
  assign dqs_i = dqs_oe ? dqs_o : clk_sys;
  ddr_read_dev #(.ADR_W(8), .ROW_W(13)) dut_u (
    .clk_sys, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
    .wb_dat_w, .wb_dat_r, .wb_ack, .link_ck, .cke, .cs_b, .ras_b, .cas_b,
    .we_b, .ba, .addr, .dq_i, .dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe
  );
  ddr_ctrl_model ctl_u (
    .link_ck, .cke, .cs_b, .ras_b, .cas_b, .we_b, .ba, .addr
  );
  // ==========
  // clock and watchdog
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #2_000_000;
    n_mismatch++;
    end_of_test;
  end
  // ==========
  // checking helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // burst position of element k after column col
  function automatic logic [3:0] pos(input logic [3:0] col, input int k);
    logic [3:0] m;
    m = (cur_bl == `BL_2) ? `MASK_2 : (cur_bl == `BL_4) ? `MASK_4 : `MASK_8;
    pos = cur_il ? (col & ~m) | ((col ^ 4'(k)) & m)
                 : (col & ~m) | ((col + 4'(k)) & m);
  endfunction
  // one element per strobe change while the data pins are driven
  always @(posedge clk_sys)
  begin
    if (dq_oe === 1'b1 && (oe_d !== 1'b1 || dqs_o !== dqs_d))
    begin
      if (oe_d !== 1'b1)
        chk({dqs_o, dqs_oe}, 2'b11, "dqs first");
      if (got.size() == 0)
        t_first = $realtime;
      got.push_back(dq_o);
    end
    oe_d <= dq_oe;
    dqs_d <= dqs_o;
  end
  // ==========
  // classic wishbone single cycle, waits for ack under a bound
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (wb_ack === 1'b1)
        break;
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n == 20)
    begin
      n_mismatch++;
      end_of_test;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, e, nm);
  endtask
  // program a mode and read it back
  task mode(input logic [2:0] clc, input logic il, input logic [2:0] blc);
    ctl_u.cmd(`CMD_MSET, `BA_MODE, {6'h00, clc, il, blc});
    ctl_u.no_operation_cmd(1);
    rdchk(`ADR_MODE, {24'h0, 1'b1, clc, il, blc}, "mode");
    hp = clc == `CL_2 ? 4 : clc == `CL_25 ? 5 : 6;
    cur_bl = blc;
    cur_il = il;
  endtask
  // read, then a second command gap cycles later, then compare output
  task sc(input logic [2:0] c2, input int gap);
    logic [3:0] a, b;
    int bl, n1, n2, k;
    a = 4'($random(seed));
    b = 4'($random(seed));
    bl = 1 << cur_bl;
    n1 = (c2 inside {`CMD_READ, `CMD_BST, `CMD_PRE} && 2 * gap < bl)
      ? 2 * gap : bl;
    n2 = (c2 == `CMD_READ) ? bl : 0;
    got.delete();
    ctl_u.cmd(`CMD_READ, 2'h0, {9'h000, a});
    t0 = ctl_u.t_cmd;
    ctl_u.no_operation_cmd(gap - 1);
    ctl_u.cmd(c2, 2'h0, {2'h0, c2 == `CMD_PRE, 6'h00, b});
    ctl_u.no_operation_cmd(14);
    chk(got.size(), drv ? n1 + n2 : 0, "count");
    chk(dq_oe, 1'b0, "oe idle");
    for (k = 0; k < got.size() && k < n1 + n2; k++)
      chk(got[k], mem[k < n1 ? pos(a, k) : pos(b, k - n1)], "data");
    if (got.size() > 0)
      chk(t_first - t0 > hp * 200 + 100 && t_first - t0 < hp * 200 + 250,
        1'b1, "latency");
  endtask
  // ==========
  // main sequence
  initial
  begin
    seed = 32'he9cf;
    drv = 1'b1;
    cls = '{`CL_2, `CL_25, `CL_3};
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdchk(`ADR_STATUS, 32'h0000_0000, "status rst");
    rdchk(`ADR_MODE, 32'h0000_0032, "mode rst");
    rdchk(`ADR_CTRL, 32'h0000_0001, "ctrl rst");
    for (i = 0; i < 16; i++)
    begin
      mem[i] = 16'($random(seed));
      wb(1'b1, 8'h40 + 8'(i * 4), {16'h0000, mem[i]});
    end
    rdchk(8'h44, {16'h0000, mem[1]}, "mem word");
    wb(1'b1, 8'h0c, 32'hffff_ffff);
    rdchk(8'h0c, 32'h0000_0000, "unmapped");
    ctl_u.power_up();
    rdchk(`ADR_STATUS, 32'h0000_002c, "status init");
    rdchk(`ADR_MODE, 32'h0000_00b2, "mode init");
    ctl_u.cmd(`CMD_ROWOPEN, 2'h0, 13'h0000);
    for (i = 0; i < 18; i++)
    begin
      mode(cls[i % 3], i / 9, 3'(1 + (i / 3) % 3));
      sc(`CMD_NOP, 1);
    end
    mode(`CL_3, 1'b0, `BL_4);
    sc(`CMD_READ, 2);
    sc(`CMD_READ, 1);
    sc(`CMD_PRE, 2);
    sc(`CMD_REF, 1);
    mode(`CL_2, 1'b1, `BL_8);
    sc(`CMD_READ, 2);
    sc(`CMD_BST, 2);
    ctl_u.cmd(`CMD_WRITE, 2'h0, 13'h0000);
    ctl_u.no_operation_cmd(1);
    sc(`CMD_PRE, 2);
    for (i = 0; i < 4; i++)
      sc(`CMD_READ, ($random(seed) & 3) + 1);
    wb(1'b1, `ADR_CTRL, 32'h0000_0000);
    drv = 1'b0;
    sc(`CMD_NOP, 1);
    ctl_u.cmd(`CMD_MSET, `BA_EXT, 13'h0001);
    ctl_u.no_operation_cmd(1);
    rdchk(`ADR_MODE, 32'h0000_002b, "loop off");
    end_of_test;
  end
endmodule
